// ---- acc_conv_ctrl.sv ----
// Overview of operation
// - Converter runs only while enable bit set
// - Idle-stop bit halts module in idle
// - Codes 000/001 integer sixteen-bit formats
// - Codes 010/011 fractional sixteen-bit formats
// - Codes 100/101 integer thirty-two-bit formats
// - Codes 110/111 fractional thirty-two-bit formats
// - Code 111 internal counter auto converts
// - Codes 010/011 timer and charge-unit triggers
// - Code 001 external pin edge triggers
// - Code 000 software clear starts conversion
// - Auto start makes hardware set sample
// - Nonzero source: hardware clears sample
// - Done flag set when conversion ends
// - Done cleared by zero, never set
// - Clearing done leaves operation untouched
// - Done cleared at each conversion start
module acc_conv_ctrl
  import acc_pkg::*;
#(
  parameter int RES_W = 10
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  // AXI4-Lite write response
  output logic      [1:0]       s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  // AXI4-Lite read data
  output logic      [31:0]      s_axi_rdata,
  output logic      [1:0]       s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  // Device state and trigger sources
  input  wire logic             cpu_idle,
  input  wire logic             ext_int0_pin,
  input  wire logic             timer3_match,
  input  wire logic             ctu_trigger,
  // Analog core
  output logic                  sample_en,
  output logic                  conv_start,
  input  wire logic             conv_done,
  input  wire logic [RES_W-1:0] conv_result,
  // Interrupt
  output logic                  irq
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchroniser and edge detect
  logic pin_s1_q;
  logic pin_s2_q;
  logic pin_s3_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
    end else begin
      pin_s1_q <= ext_int0_pin;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // Active transition taken as rising edge
  wire logic pin_rise = pin_s2_q & ~pin_s3_q;

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [31:0]         ctrl_q;
  logic [31:0]         result_q;
  logic [ACC_IRQ_W-1:0] stat_q;
  logic [ACC_IRQ_W-1:0] mask_q;
  acc_state_e          state_q;
  logic [4:0]          cnt_q;

  wire logic       on_bit     = ctrl_q[ACC_BIT_ON];
  wire logic       idle_bit   = ctrl_q[ACC_BIT_IDLE];
  wire logic [2:0] result_format       = ctrl_q[ACC_RESULT_FORMAT_LSB +: 3];
  wire logic [2:0] trig_sel   = ctrl_q[ACC_TRIG_LSB +: 3];
  wire logic       auto_start = ctrl_q[ACC_BIT_AUTO_START];
  wire logic       one_shot   = ctrl_q[ACC_BIT_CLRAS];
  wire logic       sample_bit = ctrl_q[ACC_BIT_SAMPLE];

  wire logic active = on_bit & ~(idle_bit & cpu_idle);

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  logic        aw_hold_q;
  logic        w_hold_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;

  assign s_axi_awready = ~aw_hold_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_hold_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  wire logic aw_fire = s_axi_awvalid & s_axi_awready;
  wire logic w_fire  = s_axi_wvalid & s_axi_wready;
  wire logic aw_have = aw_hold_q | aw_fire;
  wire logic w_have  = w_hold_q | w_fire;
  wire logic wr_go   = aw_have & w_have;

  wire logic [7:0]  wr_addr = aw_hold_q ? awaddr_q : s_axi_awaddr;
  wire logic [31:0] wr_data = w_hold_q ? wdata_q : s_axi_wdata;
  wire logic [3:0]  wr_strb = w_hold_q ? wstrb_q : s_axi_wstrb;
  wire logic [31:0] wr_bmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};

  wire logic wr_ctrl = wr_go & (wr_addr == ACC_OFF_CTRL);
  wire logic wr_stat = wr_go & (wr_addr == ACC_OFF_STATUS);
  wire logic wr_mask = wr_go & (wr_addr == ACC_OFF_MASK);
  wire logic wr_ok   = wr_ctrl | wr_stat | wr_mask;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q    <= 1'b0;
      w_hold_q     <= 1'b0;
      awaddr_q     <= 8'h00;
      wdata_q      <= 32'h0000_0000;
      wstrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else begin
      if (aw_fire) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (w_fire) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      aw_hold_q <= aw_have & ~wr_go;
      w_hold_q  <= w_have & ~wr_go;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  wire logic [31:0] rd_word =
    (s_axi_araddr == ACC_OFF_CTRL)   ? ctrl_q :
    (s_axi_araddr == ACC_OFF_RESULT) ? result_q :
    (s_axi_araddr == ACC_OFF_STATUS) ? {{(32-ACC_IRQ_W){1'b0}}, stat_q} :
    (s_axi_araddr == ACC_OFF_MASK)   ? {{(32-ACC_IRQ_W){1'b0}}, mask_q} : 32'h0000_0000;
  wire logic rd_ok = (s_axi_araddr == ACC_OFF_CTRL) | (s_axi_araddr == ACC_OFF_RESULT) |
                     (s_axi_araddr == ACC_OFF_STATUS) | (s_axi_araddr == ACC_OFF_MASK);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Trigger selection and sequencing
  wire logic auto_done = (cnt_q == 5'(ACC_AUTO_SAMPLE_CYC - 1));
  wire logic conv_tmo  = (cnt_q == 5'(ACC_CONV_CYC - 1));

  logic hw_trig;
  always_comb begin
    unique case (trig_sel)
      ACC_TRG_EXTPIN: hw_trig = pin_rise;
      ACC_TRG_TIMER:  hw_trig = timer3_match;
      ACC_TRG_CTU:    hw_trig = ctu_trigger;
      ACC_TRG_AUTO:   hw_trig = auto_done;
      default:        hw_trig = 1'b0;
    endcase
  end

  // Software write of the control word, with sample bit from the bus
  wire logic [31:0] ctrl_wr = (ctrl_q & ~(ACC_CTRL_WMASK & wr_bmask)) |
                              (wr_data & ACC_CTRL_WMASK & wr_bmask);
  wire logic sw_sample_clr = wr_ctrl & wr_strb[0] & sample_bit & ~wr_data[ACC_BIT_SAMPLE];

  wire logic in_sample  = (state_q == ACC_SAMPLE);
  wire logic start_conv = active & in_sample &
                          ((trig_sel == ACC_TRG_MANUAL) ? sw_sample_clr : hw_trig);
  wire logic finish     = (state_q == ACC_CONV) & conv_done;
  wire logic sample_go  = active & (state_q == ACC_IDLE) & (sample_bit | auto_start);

  assign sample_en  = in_sample & active;
  assign conv_start = start_conv;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ACC_IDLE;
      cnt_q   <= 5'd0;
    end else if (!active) begin
      state_q <= ACC_IDLE;
      cnt_q   <= 5'd0;
    end else begin
      unique case (state_q)
        ACC_IDLE: begin
          cnt_q <= 5'd0;
          if (sample_go) begin
            state_q <= ACC_SAMPLE;
          end
        end
        ACC_SAMPLE: begin
          cnt_q <= auto_done ? cnt_q : cnt_q + 5'd1;
          if (start_conv) begin
            state_q <= ACC_CONV;
            cnt_q   <= 5'd0;
          end
        end
        ACC_CONV: begin
          cnt_q <= cnt_q + 5'd1;
          if (finish | conv_tmo) begin
            state_q <= ACC_IDLE;
          end
        end
        default: state_q <= ACC_IDLE;
      endcase
    end
  end

  logic [31:0] fmt_word;

  acc_result_format #(.RES_W(RES_W)) i_acc_result_format (
    .raw  (conv_result),
    .fmt  (result_format),
    .word (fmt_word)
  );

  ////////////////////////////////////////////////////////////////////////
  // Control register with hardware-owned sample and done bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q   <= ACC_CTRL_RESET;
      result_q <= 32'h0000_0000;
    end else begin
      if (wr_ctrl) begin
        ctrl_q[31:2] <= ctrl_wr[31:2];
        // Only a write of zero affects done
        if (wr_strb[0] & ~wr_data[ACC_BIT_DONE]) begin
          ctrl_q[ACC_BIT_DONE] <= 1'b0;
        end
        ctrl_q[ACC_BIT_SAMPLE] <= ctrl_wr[ACC_BIT_SAMPLE];
      end
      if (sample_go & auto_start) begin
        ctrl_q[ACC_BIT_SAMPLE] <= 1'b1;
      end
      if (start_conv) begin
        ctrl_q[ACC_BIT_SAMPLE] <= 1'b0;
        ctrl_q[ACC_BIT_DONE] <= 1'b0;
      end
      if (finish) begin
        ctrl_q[ACC_BIT_DONE] <= 1'b1;
        result_q             <= fmt_word;
        // One-shot auto sampling stops after this result
        if (one_shot) begin
          ctrl_q[ACC_BIT_AUTO_START] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt status, set wins over write-one-to-clear
  wire logic [ACC_IRQ_W-1:0] stat_set = {start_conv, finish};
  wire logic [ACC_IRQ_W-1:0] stat_clr = (wr_stat & wr_strb[0]) ? wr_data[ACC_IRQ_W-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= '0;
      mask_q <= '0;
    end else begin
      stat_q <= (stat_q & ~stat_clr) | stat_set;
      if (wr_mask & wr_strb[0]) begin
        mask_q <= wr_data[ACC_IRQ_W-1:0];
      end
    end
  end

  assign irq = |(stat_q & mask_q);

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_off_no_sample: assert property (@(posedge aclk) disable iff (!aresetn)
    !on_bit |=> state_q == ACC_IDLE) else $error("sampling while disabled");
  a_idle_stop_halt: assert property (@(posedge aclk) disable iff (!aresetn)
    (idle_bit && cpu_idle) |-> !sample_en && !conv_start) else $error("runs in idle");
  a_done_sets_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    finish |=> ctrl_q[ACC_BIT_DONE]) else $error("done not set");
  a_start_clears_done: assert property (@(posedge aclk) disable iff (!aresetn)
    start_conv |=> !ctrl_q[ACC_BIT_DONE] && !sample_bit && state_q == ACC_CONV) else $error("start bad");
  a_done_no_sw_set: assert property (@(posedge aclk) disable iff (!aresetn)
    (!ctrl_q[ACC_BIT_DONE] && !finish) |=> !ctrl_q[ACC_BIT_DONE]) else $error("done set by write");
  a_reserved_no_trig: assert property (@(posedge aclk) disable iff (!aresetn)
    (trig_sel inside {3'b100, 3'b101, 3'b110}) |-> !conv_start) else $error("reserved trigger");
  // Software may drop enable or change source mid-period; only an undisturbed period must fire
  a_auto_period: assert property (@(posedge aclk) disable iff (!aresetn)
    (trig_sel == ACC_TRG_AUTO && $rose(sample_en) && on_bit && !idle_bit) |->
    ##15 (conv_start || !on_bit || trig_sel != ACC_TRG_AUTO)) else $error("auto period wrong");
  a_pin_edge_trig: assert property (@(posedge aclk) disable iff (!aresetn)
    (trig_sel == ACC_TRG_EXTPIN && conv_start) |-> $past(ext_int0_pin, 2) && !$past(ext_int0_pin, 3))
    else $error("pin trigger without edge");
  a_clear_keeps_conv: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_q == ACC_CONV && !finish && !conv_tmo && active) |=> state_q == ACC_CONV) else $error("conv lost");
  a_auto_sets_sample: assert property (@(posedge aclk) disable iff (!aresetn)
    (sample_go && auto_start) |=> sample_bit && in_sample) else $error("auto start missed");
  a_bvalid_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid) else $error("write response dropped");
  a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
    (finish && mask_q[ACC_IRQ_DONE]) |=> irq) else $error("irq missing");

  c_manual_conv: cover property (@(posedge aclk) disable iff (!aresetn)
    trig_sel == ACC_TRG_MANUAL && sw_sample_clr && in_sample);
  c_auto_conv: cover property (@(posedge aclk) disable iff (!aresetn) trig_sel == ACC_TRG_AUTO && finish);
  c_timer_conv: cover property (@(posedge aclk) disable iff (!aresetn) trig_sel == ACC_TRG_TIMER && start_conv);
  c_pin_conv: cover property (@(posedge aclk) disable iff (!aresetn) trig_sel == ACC_TRG_EXTPIN && start_conv);
  c_idle_stop: cover property (@(posedge aclk) disable iff (!aresetn) idle_bit && cpu_idle && on_bit);

endmodule

// ---- acc_pkg.sv ----
package acc_pkg;

  // Register byte offsets
  localparam logic [7:0] ACC_OFF_CTRL   = 8'h00;
  localparam logic [7:0] ACC_OFF_RESULT = 8'h04;
  localparam logic [7:0] ACC_OFF_STATUS = 8'h08;
  localparam logic [7:0] ACC_OFF_MASK   = 8'h0c;

  // Control register field positions
  localparam int ACC_BIT_ON         = 15;
  localparam int ACC_BIT_IDLE       = 13;
  localparam int ACC_RESULT_FORMAT_LSB       = 8;
  localparam int ACC_TRIG_LSB       = 5;
  localparam int ACC_BIT_CLRAS      = 4;
  localparam int ACC_BIT_AUTO_START = 2;
  localparam int ACC_BIT_SAMPLE     = 1;
  localparam int ACC_BIT_DONE       = 0;

  // Writable control bits; others read as zero
  localparam logic [31:0] ACC_CTRL_WMASK = 32'h0000_a7f7;
  localparam logic [31:0] ACC_CTRL_RESET = 32'h0000_0000;

  // Interrupt status bits
  localparam int ACC_IRQ_DONE = 0;
  localparam int ACC_IRQ_TRIG = 1;
  localparam int ACC_IRQ_W    = 2;

  // Internal auto-convert sample time and conversion timeout
  localparam int ACC_AUTO_SAMPLE_CYC = 16;
  localparam int ACC_CONV_CYC        = 12;

  typedef enum logic [1:0] {
    ACC_IDLE   = 2'b00,
    ACC_SAMPLE = 2'b01,
    ACC_CONV   = 2'b11
  } acc_state_e;

  typedef enum logic [2:0] {
    ACC_TRG_MANUAL = 3'b000,
    ACC_TRG_EXTPIN = 3'b001,
    ACC_TRG_TIMER  = 3'b010,
    ACC_TRG_CTU    = 3'b011,
    ACC_TRG_AUTO   = 3'b111
  } acc_trig_e;

endpackage

// ---- acc_result_format.sv ----
module acc_result_format
  import acc_pkg::*;
#(
  parameter int RES_W = 10
) (
  // Raw result and format code
  input  wire logic [RES_W-1:0] raw,
  input  wire logic [2:0]       fmt,
  // Formatted word
  output logic      [31:0]      word
);

  wire logic        sgn      = raw[RES_W-1];
  wire logic [31:0] int_zero = {{(32-RES_W){1'b0}}, raw};
  wire logic [15:0] int_s16  = {{(16-RES_W){sgn}}, raw};
  wire logic [31:0] int_s32  = {{(32-RES_W){sgn}}, raw};
  wire logic [15:0] frac16   = {raw, {(16-RES_W){1'b0}}};
  wire logic [31:0] frac32   = {raw, {(32-RES_W){1'b0}}};

  always_comb begin
    unique case (fmt)
      3'b000:  word = int_zero;
      3'b001:  word = {16'h0000, int_s16};
      3'b010:  word = {16'h0000, frac16};
      3'b011:  word = {16'h0000, frac16};
      3'b100:  word = int_zero;
      3'b101:  word = int_s32;
      3'b110:  word = frac32;
      3'b111:  word = frac32;
    endcase
  end

endmodule

// ---- acc_analog_model.sv ----
module acc_analog_model
  import acc_pkg::*;
#(
  parameter int LAT = 8
) (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Controller side
  input  wire logic       conv_start,
  output logic            conv_done,
  output logic      [9:0] conv_result,
  // Value the bench wants converted
  input  wire logic [9:0] value
);
  logic       busy_q;
  logic [3:0] cnt_q;

  // Latency kept below the controller's abandon window
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_q <= 1'b0;
      cnt_q  <= 4'h0;
    end else if (conv_start) begin
      busy_q <= 1'b1;
      cnt_q  <= 4'(LAT);
    end else if (busy_q) begin
      cnt_q <= cnt_q - 4'h1;
      if (cnt_q == 4'h1) begin
        busy_q <= 1'b0;
      end
    end
  end

  assign conv_done   = busy_q && (cnt_q == 4'h1);
  // Outside the done pulse the result lines carry junk, not the last value
  assign conv_result = conv_done ? value : ~value;
endmodule

// ---- acc_conv_ctrl_tb.sv ----
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end

module acc_conv_ctrl_tb;
  import acc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [31:0] ON   = 32'h1 << ACC_BIT_ON;
  localparam logic [31:0] IDL  = 32'h1 << ACC_BIT_IDLE;
  localparam logic [31:0] AUTO = 32'h1 << ACC_BIT_AUTO_START;
  localparam logic [31:0] SMPL = 32'h1 << ACC_BIT_SAMPLE;
  localparam logic [31:0] DONE = 32'h1 << ACC_BIT_DONE;

  logic        aclk, aresetn, aw_valid, aw_ready, w_valid, w_ready, b_valid, b_ready;
  logic        ar_valid, ar_ready, r_valid, r_ready, cpu_idle, pin, tmr, ctu;
  logic        sample_en, conv_start, conv_done, irq;
  logic [7:0]  aw_addr, ar_addr;
  logic [31:0] w_data, r_data, rv;
  logic [3:0]  w_strb;
  logic [1:0]  b_resp, r_resp, resp;
  logic [9:0]  conv_result, value;
  int          err_count, n_compared;

  acc_conv_ctrl i_acc_conv_ctrl (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(aw_addr), .s_axi_awvalid(aw_valid), .s_axi_awready(aw_ready),
    .s_axi_wdata(w_data), .s_axi_wstrb(w_strb), .s_axi_wvalid(w_valid), .s_axi_wready(w_ready),
    .s_axi_bresp(b_resp), .s_axi_bvalid(b_valid), .s_axi_bready(b_ready),
    .s_axi_araddr(ar_addr), .s_axi_arvalid(ar_valid), .s_axi_arready(ar_ready),
    .s_axi_rdata(r_data), .s_axi_rresp(r_resp), .s_axi_rvalid(r_valid), .s_axi_rready(r_ready),
    .cpu_idle(cpu_idle), .ext_int0_pin(pin), .timer3_match(tmr), .ctu_trigger(ctu),
    .sample_en(sample_en), .conv_start(conv_start), .conv_done(conv_done),
    .conv_result(conv_result), .irq(irq));

  acc_analog_model i_acc_analog_model (.aclk(aclk), .aresetn(aresetn), .conv_start(conv_start),
    .conv_done(conv_done), .conv_result(conv_result), .value(value));

  always #50 aclk = ~aclk;

  ////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // A response that never comes counts as a mismatch
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge aclk);
    aw_addr <= a; w_data <= d; aw_valid <= 1'b1; w_valid <= 1'b1; b_ready <= 1'b1;
    for (t = 0; t < 64; t++) begin
      @(posedge aclk);
      if (aw_valid && aw_ready) aw_valid <= 1'b0;
      if (w_valid && w_ready) w_valid <= 1'b0;
      if (b_valid === 1'b1) begin
        resp = b_resp;
        b_ready <= 1'b0;
        break;
      end
    end
    if (t == 64) err_count++;
  endtask

  task automatic rd(input logic [7:0] a);
    int t;
    @(posedge aclk);
    ar_addr <= a; ar_valid <= 1'b1; r_ready <= 1'b1;
    for (t = 0; t < 64; t++) begin
      @(posedge aclk);
      if (ar_valid && ar_ready) ar_valid <= 1'b0;
      if (r_valid === 1'b1) begin
        rv = r_data;
        resp = r_resp;
        r_ready <= 1'b0;
        break;
      end
    end
    if (t == 64) err_count++;
  endtask

  // Bounded poll; the caller judges the last value read
  task automatic poll_done();
    for (int t = 0; t < 40; t++) begin
      rd(ACC_OFF_CTRL);
      if (rv[0] === 1'b1) break;
    end
  endtask

  task automatic off();
    wr(ACC_OFF_CTRL, 32'h0);
    cyc(2);
  endtask

  task automatic fire(input int c);
    case (c)
      1: begin pin <= 1'b1; cyc(4); pin <= 1'b0; end
      2: begin tmr <= 1'b1; cyc(1); tmr <= 1'b0; end
      default: begin ctu <= 1'b1; cyc(1); ctu <= 1'b0; end
    endcase
    cyc(1);
  endtask

  function automatic logic [31:0] fmtx(input logic [9:0] r, input logic [2:0] f);
    case (f)
      3'h0, 3'h4: fmtx = {22'h0, r};
      3'h1:       fmtx = {16'h0, {6{r[9]}}, r};
      3'h2, 3'h3: fmtx = {16'h0, r, 6'h0};
      3'h5:       fmtx = {{22{r[9]}}, r};
      default:    fmtx = {r, 22'h0};
    endcase
  endfunction

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(20000);
    err_count++;
    conclude();
  end

  initial begin
    logic [31:0] fw;
    aclk = 1'b0; aresetn = 1'b0; aw_valid = 1'b0; w_valid = 1'b0; b_ready = 1'b0; ar_valid = 1'b0;
    r_ready = 1'b0; aw_addr = 8'h0; ar_addr = 8'h0; w_data = 32'h0; w_strb = 4'hf;
    cpu_idle = 1'b0; pin = 1'b0; tmr = 1'b0; ctu = 1'b0; value = 10'h0;
    err_count = 0; n_compared = 0;
    cyc(20);
    aresetn <= 1'b1;
    rd(ACC_OFF_CTRL); `CHK(rv, ACC_CTRL_RESET)
    rd(8'h10); `CHK(resp, 2'b10)
    wr(8'h10, 32'h1); `CHK(resp, 2'b10)
    wr(ACC_OFF_MASK, 32'h1); `CHK(resp, 2'b00)
    `CHK(irq, 1'b0)
    // Every result format, done left set from the previous pass
    for (int f = 0; f < 8; f++) begin
      fw = ON | (32'(f) << ACC_RESULT_FORMAT_LSB);
      value <= f[0] ? 10'h2c5 : 10'h13a;
      wr(ACC_OFF_CTRL, fw | SMPL | DONE);
      cyc(2); `CHK(sample_en, 1'b1)
      wr(ACC_OFF_CTRL, fw | DONE);
      rd(ACC_OFF_CTRL); `CHK(rv[1:0], 2'b00)
      poll_done(); `CHK(rv[0], 1'b1)
      rd(ACC_OFF_RESULT); `CHK(rv, fmtx(value, 3'(f)))
      `CHK(irq, 1'b1)
    end
    wr(ACC_OFF_STATUS, 32'h3);
    `CHK(irq, 1'b0)
    wr(ACC_OFF_MASK, 32'h0);
    // Hardware triggers; done cleared mid-conversion
    for (int c = 1; c < 4; c++) begin
      off();
      wr(ACC_OFF_CTRL, ON | (32'(c) << ACC_TRIG_LSB) | SMPL);
      cyc(2); `CHK(sample_en, 1'b1)
      fire(c);
      wr(ACC_OFF_CTRL, ON | (32'(c) << ACC_TRIG_LSB));
      poll_done(); `CHK(rv[1:0], 2'b01)
      `CHK(irq, 1'b0)
      rd(ACC_OFF_STATUS); `CHK(rv[0], 1'b1)
    end
    off();
    wr(ACC_OFF_CTRL, ON | (32'h7 << ACC_TRIG_LSB) | AUTO);
    poll_done(); `CHK(rv[0], 1'b1)
    cyc(3); `CHK(sample_en, 1'b1)
    for (int c = 4; c < 7; c++) begin
      off();
      wr(ACC_OFF_CTRL, ON | (32'(c) << ACC_TRIG_LSB) | SMPL);
      fire(1); fire(2); fire(3);
      cyc(20);
      rd(ACC_OFF_CTRL); `CHK(rv[1:0], 2'b10)
    end
    off();
    wr(ACC_OFF_CTRL, SMPL);
    cyc(3); `CHK(sample_en, 1'b0)
    off();
    cpu_idle <= 1'b1;
    wr(ACC_OFF_CTRL, ON | SMPL);
    cyc(3); `CHK(sample_en, 1'b1)
    off();
    wr(ACC_OFF_CTRL, ON | IDL | SMPL);
    cyc(3); `CHK(sample_en, 1'b0)
    cpu_idle <= 1'b0;
    conclude();
  end
endmodule
